// [design/scan_port_pkg.sv]
package scan_port_pkg;
  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam int CHAIN_LEN = 98;
  localparam logic [2:0] CODE_EXTERNAL = 3'h0;
  localparam logic [2:0] CODE_SAMPLE = 3'h4;
  localparam logic [2:0] CODE_IDENT = 3'h6;
  localparam logic [2:0] CODE_BYPASS = 3'h7;
  // Value loaded into the instruction register in capture-IR
  localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;
  localparam logic [2:0] IR_RESET_VALUE = 3'h6;
  // Identity fields: values arbitrary
  localparam logic [10:0] MAKER_CODE = 11'h123;
  localparam logic [15:0] PART_CODE = 16'hABCD;
  localparam logic [3:0] REVISION_CODE = 4'h1;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_PART_LSB = 12;
  localparam int ID_REV_LSB = 28;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040, ST_EXIT2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000, ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic testClock;
    logic modeSelect;
    logic dataIn;
  } scan_pins_t;
endpackage : scan_port_pkg

// [design/boundary_scan_test_port.sv]
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port
  import scan_port_pkg::*;
#(
  parameter int CHAIN_BITS = CHAIN_LEN
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire scan_pins_t scanPins,
  input wire logic [CHAIN_BITS-1:0] pinCapture,
  input wire logic [CHAIN_BITS-1:0] functionalOut,
  output logic dataOut,
  output logic dataOutEn,
  output logic [CHAIN_BITS-1:0] pinDrive,
  output logic [IR_WIDTH-1:0] activeInstruction
);
  logic rstMeta, rstSync;
  logic [2:0] pinMeta, pinSync;
  logic clkPrev;
  tap_state_t state, next_state;
  logic [IR_WIDTH-1:0] irShift;
  logic [ID_WIDTH-1:0] idShift;
  logic bypassBit;
  logic [CHAIN_BITS-1:0] chainShift, chainHold;
  logic rise, fall, tms, tdi, externalMode;
  logic [ID_WIDTH-1:0] idValue;

  assign idValue = {REVISION_CODE, PART_CODE, MAKER_CODE, 1'b1};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Test pins are asynchronous to clk; edges found after two flops
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      clkPrev <= 1'b0;
    end else if (clkEn) begin
      pinMeta <= scanPins;
      pinSync <= pinMeta;
      clkPrev <= pinSync[2];
    end
  end

  assign rise = clkEn && pinSync[2] && !clkPrev;
  assign fall = clkEn && !pinSync[2] && clkPrev;
  assign tms = pinSync[1];
  assign tdi = pinSync[0];

  always_comb begin
    case (state)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= ST_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      irShift <= IR_RESET_VALUE;
      activeInstruction <= IR_RESET_VALUE;
    end else if (rise) begin
      case (state)
        ST_RESET: activeInstruction <= IR_RESET_VALUE;
        ST_CAP_IR: irShift <= IR_CAPTURE_VALUE;
        ST_SHIFT_IR: irShift <= {tdi, irShift[IR_WIDTH-1:1]};
        ST_UPD_IR: activeInstruction <= irShift;
        default: irShift <= irShift;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      idShift <= '0;
      bypassBit <= 1'b0;
      chainShift <= '0;
    end else if (rise) begin
      if (state == ST_CAP_DR) begin
        idShift <= idValue;
        bypassBit <= 1'b0;
        chainShift <= pinCapture;
      end else if (state == ST_SHIFT_DR) begin
        case (activeInstruction)
          CODE_EXTERNAL, CODE_SAMPLE:
            chainShift <= {tdi, chainShift[CHAIN_BITS-1:1]};
          CODE_IDENT: idShift <= {tdi, idShift[ID_WIDTH-1:1]};
          default: bypassBit <= tdi;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      chainHold <= '0;
    end else if (rise && state == ST_UPD_DR &&
                 (activeInstruction == CODE_EXTERNAL ||
                  activeInstruction == CODE_SAMPLE)) begin
      chainHold <= chainShift;
    end
  end

  assign externalMode = (activeInstruction == CODE_EXTERNAL);

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinDrive <= '0;
    end else if (clkEn) begin
      // Sample keeps the functional path on the pins
      pinDrive <= externalMode ? chainHold : functionalOut;
    end
  end

  // Output changes on falling test clock, as the far end samples on rise
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
    end else if (fall) begin
      dataOutEn <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
      if (state == ST_SHIFT_IR) begin
        dataOut <= irShift[0];
      end else begin
        case (activeInstruction)
          CODE_EXTERNAL, CODE_SAMPLE: dataOut <= chainShift[0];
          CODE_IDENT: dataOut <= idShift[0];
          default: dataOut <= bypassBit;
        endcase
      end
    end
  end

  property p_bypass_delay;
    @(posedge clk) disable iff (!rstSync)
      (rise && state == ST_SHIFT_DR && activeInstruction == CODE_BYPASS)
      |=> (bypassBit == $past(tdi));
  endproperty
  a_bypass_delay: assert property (p_bypass_delay)
    else $error("bypass bit did not take input");

  property p_reset_hold;
    @(posedge clk) disable iff (!rstSync)
      (rise && tms && state == ST_RESET) |=> state == ST_RESET;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("left reset state with mode high");

  property p_no_move;
    @(posedge clk) disable iff (!rstSync)
      !rise |=> $stable(state);
  endproperty
  a_no_move: assert property (p_no_move)
    else $error("state moved without test clock rise");

  property p_ident_capture;
    @(posedge clk) disable iff (!rstSync)
      (rise && state == ST_CAP_DR) |=> idShift[0] == 1'b1;
  endproperty
  a_ident_capture: assert property (p_ident_capture)
    else $error("identity bit zero not one");

  property p_ir_shift;
    @(posedge clk) disable iff (!rstSync)
      (rise && state == ST_SHIFT_IR) |=> irShift[IR_WIDTH-1] == $past(tdi);
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("instruction shift wrong");

  property p_chain_capture;
    @(posedge clk) disable iff (!rstSync)
      (rise && state == ST_CAP_DR) |=> chainShift == $past(pinCapture);
  endproperty
  a_chain_capture: assert property (p_chain_capture)
    else $error("chain did not capture pins");

  property p_sample_path;
    @(posedge clk) disable iff (!rstSync)
      (clkEn && activeInstruction == CODE_SAMPLE && $stable(activeInstruction))
      |=> pinDrive == $past(functionalOut);
  endproperty
  a_sample_path: assert property (p_sample_path)
    else $error("sample disturbed functional path");

  property p_extest_drive;
    @(posedge clk) disable iff (!rstSync)
      (clkEn && externalMode && $stable(activeInstruction))
      |=> pinDrive == $past(chainHold);
  endproperty
  a_extest_drive: assert property (p_extest_drive)
    else $error("external test not driving chain");

  sequence s_ident_shift;
    rise && state == ST_SHIFT_DR && activeInstruction == CODE_IDENT;
  endsequence
  property p_ident_lsb;
    @(posedge clk) disable iff (!rstSync)
      s_ident_shift |=> idShift[ID_WIDTH-1] == $past(tdi);
  endproperty
  a_ident_lsb: assert property (p_ident_lsb)
    else $error("identity not shifted LSB first");
endmodule : boundary_scan_test_port
`default_nettype wire

// [test/scan_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_controller_model
  import scan_port_pkg::*;
(
  input wire logic clk,
  input wire logic dataOut,
  output scan_pins_t scanPins
);
  initial scanPins = '0;

  // Test clock rests low between calls; output sampled before the fall
  task automatic tck(input logic m, input logic d, output logic o);
    @(posedge clk);
    scanPins.modeSelect <= m;
    scanPins.dataIn <= d;
    repeat (3) @(posedge clk);
    scanPins.testClock <= 1'b1;
    repeat (4) @(posedge clk);
    o = dataOut;
    scanPins.testClock <= 1'b0;
  endtask : tck

  task automatic walk(input logic [7:0] ms, input int n);
    logic o;
    for (int i = 0; i < n; i++) tck(ms[i], 1'b0, o);
  endtask : walk

  task automatic shift(input int n, input logic [127:0] din,
                       output logic [127:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) tck(i == n - 1, din[i], dout[i]);
    scanPins.dataIn <= ~din[n-1];
    walk(8'h01, 2);
  endtask : shift

  task automatic load_ir(input logic [2:0] code, output logic [127:0] cap);
    walk(8'h03, 4);
    shift(3, {125'h0, code}, cap);
  endtask : load_ir

  task automatic run_dr(input int n, input logic [127:0] din,
                        output logic [127:0] dout);
    walk(8'h01, 3);
    shift(n, din, dout);
  endtask : run_dr
endmodule : scan_controller_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scan_port_pkg::*;
  localparam logic [127:0] PA = {4{32'h5A3C96E1}};
  localparam logic [127:0] PB = {4{32'hC3A50F69}};
  localparam logic [127:0] PC = {4{32'h1E87B42D}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic [CHAIN_LEN-1:0] pinCapture = '0;
  logic [CHAIN_LEN-1:0] functionalOut = '0;
  scan_pins_t scanPins;
  logic dataOut, dataOutEn;
  logic [CHAIN_LEN-1:0] pinDrive;
  logic [IR_WIDTH-1:0] activeInstruction;
  logic [127:0] r;
  int n_mismatch = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  boundary_scan_test_port #(.CHAIN_BITS(CHAIN_LEN)) dut (
    .clk(clk), .nrst(nrst), .clkEn(clkEn), .scanPins(scanPins),
    .pinCapture(pinCapture), .functionalOut(functionalOut),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .pinDrive(pinDrive),
    .activeInstruction(activeInstruction));

  scan_controller_model ctl (.clk(clk), .dataOut(dataOut),
    .scanPins(scanPins));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic t_ident();
    ctl.walk(8'h1F, 6);
    check(activeInstruction, CODE_IDENT);
    check(dataOutEn, 1'b0);
    ctl.load_ir(CODE_IDENT, r);
    check(r[2:0], IR_CAPTURE_VALUE);
    ctl.walk(8'h01, 3);
    // Let the falling test clock reach the output flops
    repeat (4) @(posedge clk);
    check(dataOutEn, 1'b1);
    check(dataOut, 1'b1);
    // One extra bit shows where the register ends
    ctl.shift(33, '0, r);
    check(r[32:0], {1'b0, REVISION_CODE, PART_CODE, MAKER_CODE, 1'b1});
  endtask : t_ident

  task automatic t_bypass();
    logic [2:0] codes [5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
    foreach (codes[i]) begin
      ctl.load_ir(codes[i], r);
      check(activeInstruction, codes[i]);
      ctl.run_dr(9, 128'h1B5, r);
      check(r[8:1], 8'hB5);
    end
  endtask : t_bypass

  task automatic t_sample();
    @(posedge clk);
    pinCapture <= PA[CHAIN_LEN-1:0];
    functionalOut <= PB[CHAIN_LEN-1:0];
    ctl.load_ir(CODE_SAMPLE, r);
    ctl.run_dr(CHAIN_LEN, PC, r);
    check(r[CHAIN_LEN-1:0], PA[CHAIN_LEN-1:0]);
    check(pinDrive, PB[CHAIN_LEN-1:0]);
  endtask : t_sample

  task automatic t_extest();
    @(posedge clk);
    pinCapture <= PC[CHAIN_LEN-1:0];
    ctl.load_ir(CODE_EXTERNAL, r);
    // Pins follow the new instruction one clock later
    @(posedge clk);
    check(pinDrive, PC[CHAIN_LEN-1:0]);
    // Four bits past the chain length come back from the input
    ctl.run_dr(CHAIN_LEN + 4, PB, r);
    check(r, {PB[3:0], PC[CHAIN_LEN-1:0]});
    @(posedge clk);
    check(pinDrive, PB[CHAIN_LEN+3:4]);
  endtask : t_extest

  task automatic t_freeze();
    @(posedge clk);
    clkEn <= 1'b0;
    // Pins toggle while frozen; nothing may move
    ctl.walk(8'h1F, 6);
    clkEn <= 1'b1;
    repeat (4) @(posedge clk);
    check(activeInstruction, CODE_EXTERNAL);
    check(pinDrive, PB[CHAIN_LEN+3:4]);
    ctl.walk(8'h1F, 6);
    check(activeInstruction, CODE_IDENT);
  endtask : t_freeze

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_ident();
    t_bypass();
    t_sample();
    t_extest();
    t_freeze();
    final_report();
  end
endmodule : tb
`default_nettype wire
